// *** rtl/rtcc_top.sv ***
// Real time clock: seconds-of-day and day counters, alarm, calibration.
// Assumes write strobes and clears come from register logic on clk;
// crystal, backup reset and backup-cell status are asynchronous pins.
//
// Behaviour
// - Crystal divided to a 1 Hz tick advancing the 17-bit seconds count.
// - Seconds count runs 0 to 86399, then returns to zero.
// - Each seconds rollover increments the 15-bit day counter.
// - Each tick sets the tick flag; unmasked flags drive the interrupt.
// - Alarm flag set when seconds and day both equal alarm values.
// - Alarm match requests power-on when system off, else only interrupts.
// - Clock enabled at power-up; writing one to disable stops counters.
// - Backup-domain reset clears counters, alarm and all backup registers.
// - After backup-domain reset, the timer-reset flag is set.
// - A 5-bit two's complement word trims the prescaler per 32768 cycles.
// - Calibration code is signed: 01111 is +15, 10000 is -16.
// - Calibration touches only the prescaler, not the slow clock output.
// - Mode 00 off, 01 off on backup cell, 11 always, 10 reserved.
// - Mode 01 suspends calibration while running from the backup cell.
`timescale 1ns/1ps
`default_nettype none

module rtcc_top
  import rtcc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Asynchronous pins
  input  wire logic              xtal_in,
  input  wire logic              backup_domain_por_n,
  input  wire logic              backup_cell_pin,
  // System state, same clock
  input  wire logic              system_on,
  // Register writes
  input  wire rtcc_wr_s          wr,
  input  wire logic [SOD_W-1:0]  wr_time,
  input  wire logic [DAY_W-1:0]  wr_day,
  input  wire logic [SOD_W-1:0]  wr_alarm_time,
  input  wire logic [DAY_W-1:0]  wr_alarm_day,
  input  wire logic [CAL_W-1:0]  wr_calib_word,
  input  wire logic [MODE_W-1:0] wr_calib_mode,
  input  wire logic              wr_disable,
  // Interrupt control
  input  wire rtcc_irq_s         irq_mask,
  input  wire rtcc_irq_s         irq_clear,
  // Status and outputs
  output logic [SOD_W-1:0]       seconds_of_day_counter,
  output logic [DAY_W-1:0]       day_counter,
  output logic [SOD_W-1:0]       alarm_time_value,
  output logic [DAY_W-1:0]       alarm_day_value,
  output logic [CAL_W-1:0]       calib_word,
  output logic [MODE_W-1:0]      calib_mode_sel,
  output logic                   clock_disable_bit,
  output rtcc_irq_s              irq_flags,
  output logic                   irq,
  output logic                   power_on_req,
  output logic                   slow_clock_out
);

  // Synchronisers
  logic xtal_s1;
  logic xtal_s2;
  logic xtal_s3;
  logic por_s1;
  logic por_s2;
  logic cell_s1;
  logic cell_s2;

  always_ff @(posedge clk) begin
    if (rst) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
      por_s1  <= 1'b0;
      por_s2  <= 1'b0;
      cell_s1 <= 1'b0;
      cell_s2 <= 1'b0;
    end else begin
      xtal_s1 <= xtal_in;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      por_s1  <= backup_domain_por_n;
      por_s2  <= por_s1;
      cell_s1 <= backup_cell_pin;
      cell_s2 <= cell_s1;
    end
  end

  logic xtal_edge;
  logic bk_reset;

  assign xtal_edge = xtal_s2 && !xtal_s3;
  assign bk_reset  = !por_s2;

  // Calibration gating and prescaler
  logic cal_active;
  logic run;
  logic tick;
  rtcc_state_e state;

  always_comb begin
    case (calib_mode_sel)
      CAL_ALL:  cal_active = 1'b1;
      CAL_MAIN: cal_active = !cell_s2;
      default:  cal_active = 1'b0;
    endcase
  end

  assign run = (state == ST_RUN) && !clock_disable_bit;

  rtcc_prescaler u_pre (
    .clk        (clk),
    .rst        (rst),
    .xtal_edge  (xtal_edge),
    .run        (run),
    .cal_active (cal_active),
    .corr       (calib_word),
    .tick       (tick)
  );

  // Main state
  rtcc_state_e      next_state;
  logic [SOD_W-1:0] next_sod;
  logic [DAY_W-1:0] next_day;
  logic [SOD_W-1:0] next_alarm_time;
  logic [DAY_W-1:0] next_alarm_day;
  logic [CAL_W-1:0] next_calib_word;
  logic [MODE_W-1:0] next_calib_mode;
  logic             next_disable;
  rtcc_irq_s        next_flags;
  logic             next_irq;
  logic             next_power_req;
  logic             tick_seen;
  logic             next_tick_seen;
  logic             match;
  logic             tick_run;

  assign tick_run = tick && run;
  // Compare once per second, after the counters have moved
  assign match = tick_seen
              && seconds_of_day_counter == alarm_time_value
              && day_counter == alarm_day_value;

  always_comb begin
    next_state      = state;
    next_sod        = seconds_of_day_counter;
    next_day        = day_counter;
    next_alarm_time = alarm_time_value;
    next_alarm_day  = alarm_day_value;
    next_calib_word = calib_word;
    next_calib_mode = calib_mode_sel;
    next_disable    = clock_disable_bit;
    next_flags      = irq_flags & ~irq_clear;
    next_tick_seen  = 1'b0;
    next_power_req  = 1'b0;
    // Backup reset clears on its first synced edge, whatever the state
    case (bk_reset ? ST_CLEAR : state)
      ST_CLEAR: begin
        // Hold everything at reset values while backup reset asserted
        next_sod        = SOD_ZERO;
        next_day        = DAY_ZERO;
        next_alarm_time = SOD_ZERO;
        next_alarm_day  = DAY_ZERO;
        next_calib_word = CAL_ZERO;
        next_calib_mode = CAL_OFF;
        next_disable    = 1'b0;
        next_flags      = IRQ_NONE;
        if (!bk_reset) begin
          next_state = ST_FLAG;
        end
      end
      ST_FLAG: begin
        next_flags.reset = 1'b1;
        next_state       = ST_RUN;
      end
      ST_RUN: begin
        if (tick_run) begin
          next_tick_seen = 1'b1;
          if (seconds_of_day_counter >= SOD_MAX) begin
            next_sod = SOD_ZERO;
            next_day = day_counter + DAY_ONE;
          end else begin
            next_sod = seconds_of_day_counter + SOD_ONE;
          end
        end
        if (wr.time_we) begin
          next_sod = wr_time;
        end
        if (wr.day_we) begin
          next_day = wr_day;
        end
        if (wr.alarm_time_we) begin
          next_alarm_time = wr_alarm_time;
        end
        if (wr.alarm_day_we) begin
          next_alarm_day = wr_alarm_day;
        end
        if (wr.calib_we) begin
          next_calib_word = wr_calib_word;
          next_calib_mode = wr_calib_mode;
        end
        if (wr.disable_we) begin
          next_disable = wr_disable;
        end
        // Set wins over a clear in the same cycle
        if (tick_run) begin
          next_flags.tick = 1'b1;
        end
        if (match) begin
          next_flags.alarm = 1'b1;
          next_power_req   = !system_on;
        end
      end
      default: begin
        next_state = ST_CLEAR;
      end
    endcase
    if (bk_reset) begin
      next_state = ST_CLEAR;
    end
    next_irq = |(next_flags & ~irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state                  <= ST_CLEAR;
      seconds_of_day_counter <= SOD_ZERO;
      day_counter            <= DAY_ZERO;
      alarm_time_value       <= SOD_ZERO;
      alarm_day_value        <= DAY_ZERO;
      calib_word             <= CAL_ZERO;
      calib_mode_sel         <= CAL_OFF;
      clock_disable_bit      <= 1'b0;
      irq_flags              <= IRQ_NONE;
      irq                    <= 1'b0;
      power_on_req           <= 1'b0;
      tick_seen              <= 1'b0;
    end else begin
      state                  <= next_state;
      seconds_of_day_counter <= next_sod;
      day_counter            <= next_day;
      alarm_time_value       <= next_alarm_time;
      alarm_day_value        <= next_alarm_day;
      calib_word             <= next_calib_word;
      calib_mode_sel         <= next_calib_mode;
      clock_disable_bit      <= next_disable;
      irq_flags              <= next_flags;
      irq                    <= next_irq;
      power_on_req           <= next_power_req;
      tick_seen              <= next_tick_seen;
    end
  end

  // Crystal passes through untouched by calibration
  assign slow_clock_out = xtal_s3;

  property p_sod_inc;
    @(posedge clk) disable iff (rst)
      (tick_run && !bk_reset && !wr.time_we
        && seconds_of_day_counter < SOD_MAX)
      |=> seconds_of_day_counter == $past(seconds_of_day_counter) + SOD_ONE;
  endproperty
  a_sod_inc: assert property (p_sod_inc)
    else $error("seconds count did not advance on tick");

  property p_sod_wrap;
    @(posedge clk) disable iff (rst)
      (tick_run && !bk_reset && !wr.time_we && !wr.day_we
        && seconds_of_day_counter == SOD_MAX)
      |=> seconds_of_day_counter == SOD_ZERO
          && day_counter == $past(day_counter) + DAY_ONE;
  endproperty
  a_sod_wrap: assert property (p_sod_wrap)
    else $error("seconds rollover or day increment wrong");

  property p_day_only_on_wrap;
    @(posedge clk) disable iff (rst)
      (state == ST_RUN && !bk_reset && !wr.day_we
        && !(tick_run && seconds_of_day_counter >= SOD_MAX))
      |=> $stable(day_counter);
  endproperty
  a_day_only_on_wrap: assert property (p_day_only_on_wrap)
    else $error("day counter moved without rollover");

  property p_tick_flag;
    @(posedge clk) disable iff (rst)
      (tick_run && !bk_reset) |=> irq_flags.tick ##1 (irq || irq_mask.tick);
  endproperty
  a_tick_flag: assert property (p_tick_flag)
    else $error("tick flag or interrupt missing");

  property p_masked_quiet;
    @(posedge clk) disable iff (rst)
      (irq_mask == 3'h7) |=> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised with all flags masked");

  property p_alarm;
    @(posedge clk) disable iff (rst)
      (match && state == ST_RUN && !bk_reset)
      |=> irq_flags.alarm && (power_on_req == !$past(system_on));
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm match did not flag as expected");

  property p_power_req_cause;
    @(posedge clk) disable iff (rst)
      power_on_req |-> $past(match) && !$past(system_on);
  endproperty
  a_power_req_cause: assert property (p_power_req_cause)
    else $error("power-on request without alarm while off");

  property p_disabled_stops;
    @(posedge clk) disable iff (rst)
      (clock_disable_bit && !bk_reset && !wr.time_we) [*2]
      |-> $stable(seconds_of_day_counter);
  endproperty
  a_disabled_stops: assert property (p_disabled_stops)
    else $error("counters moved while disabled");

  property p_bk_reset;
    @(posedge clk) disable iff (rst)
      (bk_reset && state == ST_RUN)
      |=> seconds_of_day_counter == SOD_ZERO ##0 alarm_day_value == DAY_ZERO
          ##0 calib_mode_sel == CAL_OFF ##0 !clock_disable_bit;
  endproperty
  a_bk_reset: assert property (p_bk_reset)
    else $error("backup reset did not clear state");

  property p_reset_flag;
    @(posedge clk) disable iff (rst)
      (state == ST_CLEAR && !bk_reset) |=> ##1 irq_flags.reset;
  endproperty
  a_reset_flag: assert property (p_reset_flag)
    else $error("timer-reset flag not set after reset release");

  property p_cal_gate;
    @(posedge clk) disable iff (rst)
      (calib_mode_sel == CAL_OFF || calib_mode_sel == CAL_RSVD
        || (calib_mode_sel == CAL_MAIN && cell_s2)) |-> !cal_active;
  endproperty
  a_cal_gate: assert property (p_cal_gate)
    else $error("calibration active in a mode that forbids it");

endmodule

`default_nettype wire

// *** rtl/rtcc_pkg.sv ***
// Constants, carriers and state codes of the real time clock block.
// Assumes one 250 MHz system clock; the crystal arrives as a plain level.
package rtcc_pkg;

  // Field widths
  localparam int SOD_W  = 17;
  localparam int DAY_W  = 15;
  localparam int CAL_W  = 5;
  localparam int MODE_W = 2;
  localparam int PRE_W  = 16;

  // Crystal division: 32768 crystal cycles make one 1 Hz tick
  localparam int CRYSTAL_HZ = 32768;
  localparam int TICK_HZ    = 1;
  localparam logic [PRE_W-1:0] PRE_TERM =
    PRE_W'(CRYSTAL_HZ / TICK_HZ - 1);

  // Counter limits and reset values
  localparam logic [SOD_W-1:0] SOD_MAX   = 17'h1517F;
  localparam logic [SOD_W-1:0] SOD_ZERO  = 17'h00000;
  localparam logic [DAY_W-1:0] DAY_ZERO  = 15'h0000;
  localparam logic [DAY_W-1:0] DAY_ONE   = 15'h0001;
  localparam logic [SOD_W-1:0] SOD_ONE   = 17'h00001;
  localparam logic [CAL_W-1:0] CAL_ZERO  = 5'h00;
  localparam logic [PRE_W-1:0] PRE_ZERO  = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_ONE   = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_SLACK = 16'h0010;

  // Calibration mode codes
  localparam logic [MODE_W-1:0] CAL_OFF  = 2'h0;
  localparam logic [MODE_W-1:0] CAL_MAIN = 2'h1;
  localparam logic [MODE_W-1:0] CAL_RSVD = 2'h2;
  localparam logic [MODE_W-1:0] CAL_ALL  = 2'h3;

  // Interrupt flags, masks and clears share this layout
  typedef struct packed {
    logic reset;
    logic alarm;
    logic tick;
  } rtcc_irq_s;

  localparam rtcc_irq_s IRQ_NONE = 3'h0;

  // Write strobes from the serial register interface
  typedef struct packed {
    logic time_we;
    logic day_we;
    logic alarm_time_we;
    logic alarm_day_we;
    logic calib_we;
    logic disable_we;
  } rtcc_wr_s;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'h1,
    ST_FLAG  = 3'h2,
    ST_RUN   = 3'h4
  } rtcc_state_e;

endpackage

// *** rtl/rtcc_prescaler.sv ***
// Calibrated prescaler: counts crystal edges and pulses one tick per second.
// Assumes xtal_edge is a one-cycle pulse already in the clk domain.
`timescale 1ns/1ps
`default_nettype none

module rtcc_prescaler
  import rtcc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             xtal_edge,
  input  wire logic             run,
  input  wire logic             cal_active,
  input  wire logic [CAL_W-1:0] corr,
  // Tick out
  output logic                  tick
);

  logic [PRE_W-1:0] cnt;
  logic [PRE_W-1:0] next_cnt;
  logic             next_tick;
  logic [PRE_W-1:0] corr_ext;
  logic [PRE_W-1:0] term;

  // Signed correction shortens or lengthens the period
  assign corr_ext = {{(PRE_W-CAL_W){corr[CAL_W-1]}}, corr};
  assign term     = cal_active ? PRE_TERM - corr_ext : PRE_TERM;

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = PRE_ZERO;
    end else if (xtal_edge) begin
      if (cnt >= term) begin
        next_cnt  = PRE_ZERO;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + PRE_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt  <= PRE_ZERO;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  property p_tick_at_term;
    @(posedge clk) disable iff (rst)
      tick |-> $past(xtal_edge) && $past(run) && ($past(cnt) >= $past(term));
  endproperty
  a_tick_at_term: assert property (p_tick_at_term)
    else $error("tick without reaching terminal count");

  property p_cal_off_full_period;
    @(posedge clk) disable iff (rst)
      (run && xtal_edge && !cal_active && cnt == PRE_TERM) |=> tick;
  endproperty
  a_cal_off_full_period: assert property (p_cal_off_full_period)
    else $error("uncalibrated period not 32768 crystal cycles");

  property p_cnt_bounded;
    @(posedge clk) disable iff (rst)
      cnt <= PRE_TERM + PRE_SLACK;
  endproperty
  a_cnt_bounded: assert property (p_cnt_bounded)
    else $error("prescaler beyond largest calibrated terminal");

endmodule

`default_nettype wire

// *** sim/rtcc_host_model.sv ***
// Host processor model: issues register writes, masks and clears.
// Assumes the design samples strobes on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

module rtcc_host_model
  import rtcc_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Register writes
  output var  rtcc_wr_s     wr,
  output logic [SOD_W-1:0]  wr_time,
  output logic [DAY_W-1:0]  wr_day,
  output logic [SOD_W-1:0]  wr_alarm_time,
  output logic [DAY_W-1:0]  wr_alarm_day,
  output logic [CAL_W-1:0]  wr_calib_word,
  output logic [MODE_W-1:0] wr_calib_mode,
  output logic              wr_disable,
  // Interrupt control
  output var  rtcc_irq_s    irq_mask,
  output var  rtcc_irq_s    irq_clear
);
  initial begin
    wr = '0;
    {wr_time, wr_day, wr_alarm_time, wr_alarm_day} = '0;
    {wr_calib_word, wr_calib_mode, wr_disable} = '0;
    irq_mask = 3'h7;
    irq_clear = IRQ_NONE;
  end

  // Strobe for one cycle, then data lines show the inverse value
  task automatic put(input rtcc_wr_s s, input logic [SOD_W-1:0] v);
    @(negedge clk);
    wr <= s;
    {wr_time, wr_alarm_time} <= {v, v};
    {wr_day, wr_alarm_day} <= {v[DAY_W-1:0], v[DAY_W-1:0]};
    {wr_calib_mode, wr_calib_word} <= v[6:0];
    wr_disable <= v[0];
    @(negedge clk);
    wr <= '0;
    {wr_time, wr_alarm_time} <= ~{v, v};
    {wr_day, wr_alarm_day} <= ~{v[DAY_W-1:0], v[DAY_W-1:0]};
    {wr_calib_mode, wr_calib_word} <= ~v[6:0];
    wr_disable <= ~v[0];
  endtask

  // Correction word and mode given by the caller, written with the calib strobe
  task automatic calib(input logic [CAL_W-1:0] c, input logic [1:0] m);
    put(6'h02, {10'h000, m, c});
  endtask

  task automatic mask(input rtcc_irq_s m);
    @(negedge clk);
    irq_mask <= m;
  endtask

  task automatic clr(input rtcc_irq_s c);
    @(negedge clk);
    irq_clear <= c;
    @(negedge clk);
    irq_clear <= IRQ_NONE;
  endtask
endmodule

`default_nettype wire

// *** sim/rtc_time_day_alarm_calibration_bench.sv ***
// Bench: host model writes registers, bench drives pins and checks.
// Assumes the crystal may toggle every clock; one tick is about 65k clocks.
`timescale 1ns/1ps
`default_nettype none

module rtc_time_day_alarm_calibration_bench;
  import rtcc_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              xtal_in = 1'b0;
  logic              backup_domain_por_n = 1'b1;
  logic              backup_cell_pin = 1'b0;
  logic              system_on = 1'b0;
  rtcc_wr_s          wr;
  rtcc_irq_s         irq_mask, irq_clear, irq_flags;
  logic [SOD_W-1:0]  wr_time, wr_alarm_time;
  logic [SOD_W-1:0]  seconds_of_day_counter, alarm_time_value;
  logic [DAY_W-1:0]  wr_day, wr_alarm_day, day_counter, alarm_day_value;
  logic [CAL_W-1:0]  wr_calib_word, calib_word, code;
  logic [MODE_W-1:0] wr_calib_mode, calib_mode_sel;
  logic              wr_disable, clock_disable_bit, irq, power_on_req;
  logic              slow_clock_out, counting = 1'b0, slow_prev = 1'b0;
  int                errors = 0, total_checks = 0, seed = 76070;
  int                xe = 0, se = 0, m_sec = 0, m_day = 0, i, d;

  always #2 clk = ~clk;

  rtcc_top u_rtcc_top (.clk, .rst, .xtal_in, .backup_domain_por_n,
    .backup_cell_pin, .system_on, .wr, .wr_time, .wr_day, .wr_alarm_time,
    .wr_alarm_day, .wr_calib_word, .wr_calib_mode, .wr_disable, .irq_mask,
    .irq_clear, .seconds_of_day_counter, .day_counter, .alarm_time_value,
    .alarm_day_value, .calib_word, .calib_mode_sel, .clock_disable_bit,
    .irq_flags, .irq, .power_on_req, .slow_clock_out);

  rtcc_host_model u_rtcc_host_model (.clk, .wr, .wr_time, .wr_day,
    .wr_alarm_time, .wr_alarm_day, .wr_calib_word, .wr_calib_mode,
    .wr_disable, .irq_mask, .irq_clear);

  // Fastest crystal the synchroniser can follow; count its rising edges
  always @(negedge clk) begin
    xtal_in <= ~xtal_in;
    backup_cell_pin <= 1'($random(seed));
    if (counting && !xtal_in) xe++;
    if (counting && slow_clock_out && !slow_prev) se++;
    slow_prev <= slow_clock_out;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
               exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial begin
    cyc(2);
    rst <= 1'b0;
    counting <= 1'b1;
    cyc(6);
    chk(32'(seconds_of_day_counter), 32'(m_sec));
    chk(32'(day_counter), 32'(m_day));
    chk(32'(calib_mode_sel), 32'(CAL_OFF));
    chk(32'(clock_disable_bit), 32'h0);
    chk(32'(irq_flags), 32'h4);
    chk(32'(irq), 32'h0);
    $display("test reset values done");
    // Correction of at least 8 counts in either direction
    d = $random(seed);
    code = {d[4], ~d[4], d[2:0]};
    u_rtcc_host_model.calib(code, CAL_ALL);
    u_rtcc_host_model.put(6'h20, SOD_MAX);
    u_rtcc_host_model.put(6'h10, 17'h00005);
    u_rtcc_host_model.put(6'h08, 17'h00000);
    u_rtcc_host_model.put(6'h04, 17'h00006);
    u_rtcc_host_model.clr(3'h4);
    u_rtcc_host_model.mask(3'h5);
    m_sec = 86399;
    m_day = 5;
    cyc(1);
    chk(32'(calib_word), 32'(code));
    chk(32'(calib_mode_sel), 32'(CAL_ALL));
    chk(32'(seconds_of_day_counter), 32'(m_sec));
    chk(32'(day_counter), 32'(m_day));
    chk(32'(alarm_time_value), 32'h0);
    chk(32'(alarm_day_value), 32'h6);
    chk(32'(irq_flags), 32'h0);
    $display("test register writes done");
    for (i = 0; i < 70000 && seconds_of_day_counter === SOD_MAX; i++) begin
      cyc(1);
    end
    if (i == 70000) begin
      errors++;
      end_sim();
    end
    m_day = (m_sec >= 86399) ? m_day + 1 : m_day;
    m_sec = (m_sec >= 86399) ? 0 : m_sec + 1;
    d = xe - (32768 - int'($signed(code)));
    chk(32'(seconds_of_day_counter), 32'(m_sec));
    chk(32'(day_counter), 32'(m_day));
    chk(32'(irq_flags.tick), 32'h1);
    chk(32'(d >= -3 && d <= 3), 32'h1);
    chk(32'(xe - se >= 0 && xe - se <= 2), 32'h1);
    cyc(1);
    chk(32'(irq_flags.alarm), 32'h1);
    chk(32'(power_on_req), 32'h1);
    chk(32'(irq), 32'h1);
    cyc(1);
    chk(32'(power_on_req), 32'h0);
    $display("test tick and alarm done");
    u_rtcc_host_model.clr(3'h2);
    cyc(2);
    chk(32'(irq_flags), 32'h1);
    chk(32'(irq), 32'h0);
    u_rtcc_host_model.mask(3'h0);
    cyc(2);
    chk(32'(irq), 32'h1);
    u_rtcc_host_model.clr(3'h1);
    cyc(2);
    chk(32'(irq_flags), 32'h0);
    chk(32'(irq), 32'h0);
    $display("test mask and clear done");
    u_rtcc_host_model.put(6'h01, 17'h00001);
    cyc(1);
    chk(32'(clock_disable_bit), 32'h1);
    cyc(2000);
    chk(32'(seconds_of_day_counter), 32'(m_sec));
    u_rtcc_host_model.calib(code, CAL_MAIN);
    cyc(1);
    chk(32'(calib_mode_sel), 32'(CAL_MAIN));
    $display("test clock disable done");
    backup_domain_por_n <= 1'b0;
    cyc(6);
    chk(32'({seconds_of_day_counter, day_counter}), 32'h0);
    chk(32'({alarm_time_value, alarm_day_value}), 32'h0);
    chk(32'({calib_word, calib_mode_sel, clock_disable_bit}), 32'h0);
    backup_domain_por_n <= 1'b1;
    cyc(10);
    chk(32'(irq_flags), 32'h4);
    $display("test backup reset done");
    end_sim();
  end
endmodule

`default_nettype wire
